/* verilog/asf_pkg.sv */
// Constants and types shared by the status flag block.
// Assumes one clock, synchronous active-low reset, AXI4-Lite with 32-bit data.
package asf_pkg;

  localparam int DATA_W = 8;
  localparam int AXI_DATA_W = 32;
  localparam int AXI_ADDR_W = 4;

  // Byte offsets of the bus registers
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_RESULT = 4'h4;

  // Field positions in the status byte
  localparam int BIT_CARRY = 0;
  localparam int BIT_NIBBLE = 1;
  localparam int BIT_ZERO = 2;
  localparam int BIT_SLEEP = 3;
  localparam int BIT_EXPIRY = 4;
  localparam int ARITH_W = 3;

  // Values after power-on
  localparam logic [2:0] ARITH_RESET = 3'h0;
  localparam logic EXPIRY_RESET = 1'b1;
  localparam logic SLEEP_RESET = 1'b1;
  localparam logic [7:0] RESULT_RESET = 8'h00;

  // Flag masks, bit order zero, nibble, carry
  localparam logic [2:0] MASK_NONE = 3'h0;
  localparam logic [2:0] MASK_ZERO = 3'h4;
  localparam logic [2:0] MASK_ALL = 3'h7;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    OP_ADD = 4'h0,
    OP_SUB = 4'h1,
    OP_AND = 4'h2,
    OP_OR = 4'h3,
    OP_XOR = 4'h4,
    OP_CLEAR = 4'h5,
    OP_BIT_CLEAR = 4'h6,
    OP_BIT_SET = 4'h7,
    OP_SWAP = 4'h8,
    OP_MOVE = 4'h9
  } asf_op_type;

endpackage

/* verilog/asf_alu.sv */
// Result and flag generation for one core instruction.
// Purely combinational; the caller registers what it keeps.
module asf_alu (
  // Operation
  input wire asf_pkg::asf_op_type op,
  input wire logic [7:0] operand_f,
  input wire logic [7:0] operand_w,
  input wire logic [2:0] bit_sel,
  // Outputs
  output logic [7:0] result,
  output logic [2:0] flag_mask,
  output logic zero,
  output logic nibble_carry,
  output logic carry
);

  logic [7:0] addend;
  logic carry_in;
  logic [8:0] sum_full;
  logic [4:0] sum_low;

  always_comb
  begin
    addend = operand_w;
    carry_in = 1'b0;
    if (op == asf_pkg::OP_SUB)
    begin
      // Subtract as f plus two's complement of w
      addend = ~operand_w;
      carry_in = 1'b1;
    end
    sum_full = {1'b0, operand_f} + {1'b0, addend} + {8'h00, carry_in};
    sum_low = {1'b0, operand_f[3:0]} + {1'b0, addend[3:0]} + {4'h0, carry_in};
    result = operand_f;
    flag_mask = asf_pkg::MASK_NONE;
    case (op)
      asf_pkg::OP_ADD, asf_pkg::OP_SUB:
      begin
        result = sum_full[7:0];
        flag_mask = asf_pkg::MASK_ALL;
      end
      asf_pkg::OP_AND:
      begin
        result = operand_f & operand_w;
        flag_mask = asf_pkg::MASK_ZERO;
      end
      asf_pkg::OP_OR:
      begin
        result = operand_f | operand_w;
        flag_mask = asf_pkg::MASK_ZERO;
      end
      asf_pkg::OP_XOR:
      begin
        result = operand_f ^ operand_w;
        flag_mask = asf_pkg::MASK_ZERO;
      end
      asf_pkg::OP_CLEAR:
      begin
        result = 8'h00;
        flag_mask = asf_pkg::MASK_ZERO;
      end
      // These four touch no flag
      asf_pkg::OP_BIT_CLEAR: result = operand_f & ~(8'h01 << bit_sel);
      asf_pkg::OP_BIT_SET: result = operand_f | (8'h01 << bit_sel);
      asf_pkg::OP_SWAP: result = {operand_f[3:0], operand_f[7:4]};
      asf_pkg::OP_MOVE: result = operand_w;
      default: result = operand_f;
    endcase
    zero = (result == 8'h00);
    // Carry out of the adder; in subtraction one means no borrow
    nibble_carry = sum_low[4];
    carry = sum_full[8];
  end

endmodule

/* verilog/asf_reset_cause.sv */
// Watchdog expiry and sleep-entered flags.
// Event inputs are one-cycle pulses from the core; reset stands for power-on.
module asf_reset_cause (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Hardware events
  input wire logic sleep_instr,
  input wire logic watchdog_clear_instr,
  input wire logic watchdog_timeout,
  // Flags
  output logic watchdog_expiry_flag,
  output logic sleep_entered_flag
);

  logic expiry_d;
  logic expiry_q;
  logic sleep_d;
  logic sleep_q;

  always_comb
  begin
    expiry_d = expiry_q;
    sleep_d = sleep_q;
    if (watchdog_clear_instr || sleep_instr)
    begin
      expiry_d = 1'b1;
    end
    // A time-out must not be lost to a same-cycle clear
    if (watchdog_timeout)
    begin
      expiry_d = 1'b0;
    end
    if (watchdog_clear_instr)
    begin
      sleep_d = 1'b1;
    end
    if (sleep_instr)
    begin
      sleep_d = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      expiry_q <= asf_pkg::EXPIRY_RESET;
      sleep_q <= asf_pkg::SLEEP_RESET;
    end
    else
    begin
      expiry_q <= expiry_d;
      sleep_q <= sleep_d;
    end
  end

  assign watchdog_expiry_flag = expiry_q;
  assign sleep_entered_flag = sleep_q;

endmodule

/* verilog/asf_status.sv */
// Core status register with AXI4-Lite access and instruction-side flag updates.
// Assumes the core presents one instruction per cycle with its operands ready.
module asf_status (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // AXI4-Lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read address
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // AXI4-Lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Instruction port
  input wire logic instr_valid,
  input wire asf_pkg::asf_op_type instr_op,
  input wire logic [7:0] instr_operand_f,
  input wire logic [7:0] instr_operand_w,
  input wire logic [2:0] instr_bit_sel,
  input wire logic instr_dest_status,
  // Hardware events
  input wire logic sleep_instr,
  input wire logic watchdog_clear_instr,
  input wire logic watchdog_timeout,
  // Results
  output logic [7:0] result,
  output logic result_valid,
  output logic [7:0] status_flags
);

  // Instruction side
  logic [7:0] alu_result;
  logic [2:0] alu_mask;
  logic alu_zero;
  logic alu_nibble;
  logic alu_carry;
  logic [2:0] alu_flags;
  logic expiry_flag;
  logic sleep_flag;
  logic [2:0] arith_d;
  logic [2:0] arith_q;
  logic [7:0] result_d;
  logic [7:0] result_q;
  logic result_valid_d;
  logic result_valid_q;

  // Bus side
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic do_write;
  logic aw_held_d;
  logic aw_held_q;
  logic w_held_d;
  logic w_held_q;
  logic [3:0] waddr_d;
  logic [3:0] waddr_q;
  logic [7:0] wbyte_d;
  logic [7:0] wbyte_q;
  logic wlane_d;
  logic wlane_q;
  logic awready_d;
  logic awready_q;
  logic wready_d;
  logic wready_q;
  logic bvalid_d;
  logic bvalid_q;
  logic [1:0] bresp_d;
  logic [1:0] bresp_q;
  logic arready_d;
  logic arready_q;
  logic rvalid_d;
  logic rvalid_q;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic [1:0] rresp_d;
  logic [1:0] rresp_q;
  logic [7:0] status_now;

  asf_alu u_alu (
    .op(instr_op),
    .operand_f(instr_operand_f),
    .operand_w(instr_operand_w),
    .bit_sel(instr_bit_sel),
    .result(alu_result),
    .flag_mask(alu_mask),
    .zero(alu_zero),
    .nibble_carry(alu_nibble),
    .carry(alu_carry)
  );

  // Expiry and sleep flags have no write path at all
  asf_reset_cause u_reset_cause (
    .aclk(aclk),
    .aresetn(aresetn),
    .sleep_instr(sleep_instr),
    .watchdog_clear_instr(watchdog_clear_instr),
    .watchdog_timeout(watchdog_timeout),
    .watchdog_expiry_flag(expiry_flag),
    .sleep_entered_flag(sleep_flag)
  );

  assign alu_flags = {alu_zero, alu_nibble, alu_carry};
  assign status_now = {3'h0, expiry_flag, sleep_flag, arith_q};

  // Write channel: address and data taken in either order
  always_comb
  begin
    aw_take = awvalid && awready_q;
    w_take = wvalid && wready_q;
    do_write = aw_held_q && w_held_q && !bvalid_q;
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    waddr_d = waddr_q;
    wbyte_d = wbyte_q;
    wlane_d = wlane_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (aw_take)
    begin
      aw_held_d = 1'b1;
      waddr_d = awaddr;
    end
    if (w_take)
    begin
      w_held_d = 1'b1;
      wbyte_d = wdata[7:0];
      wlane_d = wstrb[0];
    end
    if (bvalid_q && bready)
    begin
      bvalid_d = 1'b0;
    end
    if (do_write)
    begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = asf_pkg::RESP_SLVERR;
      if (waddr_q[3:2] == asf_pkg::OFS_STATUS[3:2] ||
          waddr_q[3:2] == asf_pkg::OFS_RESULT[3:2])
      begin
        bresp_d = asf_pkg::RESP_OKAY;
      end
    end
    awready_d = !aw_held_d && !bvalid_d;
    wready_d = !w_held_d && !bvalid_d;
  end

  // Read channel: one read under way at a time
  always_comb
  begin
    ar_take = arvalid && arready_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rvalid_q && rready)
    begin
      rvalid_d = 1'b0;
    end
    if (ar_take)
    begin
      rvalid_d = 1'b1;
      rresp_d = asf_pkg::RESP_OKAY;
      case (araddr[3:2])
        asf_pkg::OFS_STATUS[3:2]: rdata_d = {24'h00_0000, status_now};
        asf_pkg::OFS_RESULT[3:2]: rdata_d = {24'h00_0000, result_q};
        default:
        begin
          rdata_d = 32'h0000_0000;
          rresp_d = asf_pkg::RESP_SLVERR;
        end
      endcase
    end
    arready_d = !rvalid_d;
  end

  // Arithmetic flags: bus write first, then the instruction on top
  always_comb
  begin
    arith_d = arith_q;
    result_d = result_q;
    result_valid_d = instr_valid;
    // A bus write acts like a move into the status byte
    if (do_write && wlane_q && waddr_q[3:2] == asf_pkg::OFS_STATUS[3:2])
    begin
      arith_d = wbyte_q[2:0];
    end
    if (instr_valid)
    begin
      result_d = alu_result;
      if (instr_dest_status && alu_mask == asf_pkg::MASK_NONE)
      begin
        // Upper bits of the result have nowhere to go
        arith_d = alu_result[2:0];
      end
      for (int i = 0; i < asf_pkg::ARITH_W; i++)
      begin
        if (alu_mask[i])
        begin
          // Written data for these bits is dropped in favour of the flag
          arith_d[i] = alu_flags[i];
        end
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      waddr_q <= 4'h0;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= asf_pkg::RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= asf_pkg::RESP_OKAY;
      arith_q <= asf_pkg::ARITH_RESET;
      result_q <= asf_pkg::RESULT_RESET;
      result_valid_q <= 1'b0;
    end
    else
    begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      waddr_q <= waddr_d;
      wbyte_q <= wbyte_d;
      wlane_q <= wlane_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      arith_q <= arith_d;
      result_q <= result_d;
      result_valid_q <= result_valid_d;
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign result = result_q;
  assign result_valid = result_valid_q;
  assign status_flags = status_now;

endmodule

/* tb/asf_status_monitor.sv */
// Concurrent checks on the status flag block.
// Sees only the asf_status ports; bound at the foot.
module asf_status_monitor (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Instructions and events
  input wire logic instr_valid,
  input wire asf_pkg::asf_op_type instr_op,
  input wire logic [7:0] instr_operand_f,
  input wire logic [7:0] instr_operand_w,
  input wire logic instr_dest_status,
  input wire logic sleep_instr,
  input wire logic watchdog_clear_instr,
  input wire logic watchdog_timeout,
  // Flags
  input wire logic [7:0] status_flags
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic sb;
  logic [7:0] o;
  logic [8:0] s;
  logic [4:0] nb;
  logic [2:0] exp_fl;
  logic no_borrow;
  logic no_nibble_borrow;
  logic plain_op;
  logic logic_op;
  logic clear_op;
  assign sb = instr_op == asf_pkg::OP_SUB;
  assign o = sb ? ~instr_operand_w : instr_operand_w;
  assign s = {1'b0, instr_operand_f} + {1'b0, o} + {8'h00, sb};
  assign nb = {1'b0, instr_operand_f[3:0]} + {1'b0, o[3:0]} + {4'h0, sb};
  assign exp_fl = {s[7:0] == 8'h00, nb[4], s[8]};
  // Borrow judged by magnitude, independent of any adder
  assign no_borrow = instr_operand_f >= instr_operand_w;
  assign no_nibble_borrow = instr_operand_f[3:0] >= instr_operand_w[3:0];
  assign plain_op = instr_op inside {asf_pkg::OP_BIT_CLEAR, asf_pkg::OP_BIT_SET,
    asf_pkg::OP_SWAP, asf_pkg::OP_MOVE};
  assign logic_op = instr_op inside {asf_pkg::OP_AND, asf_pkg::OP_OR, asf_pkg::OP_XOR};
  assign clear_op = instr_op == asf_pkg::OP_CLEAR;
  sequence quiet;
    !sleep_instr && !watchdog_clear_instr && !watchdog_timeout;
  endsequence
  sequence arith;
    instr_valid && (instr_op inside {asf_pkg::OP_ADD, asf_pkg::OP_SUB});
  endsequence
  sequence subtract;
    instr_valid && sb;
  endsequence
  arith_flags_a: assert property (arith |=> status_flags[2:0] == $past(exp_fl))
    else $error("arithmetic flags wrong");
  sub_borrow_a: assert property (subtract |=>
    status_flags[1:0] == {$past(no_nibble_borrow), $past(no_borrow)})
    else $error("borrow flags wrong");
  clear_zero_a: assert property (instr_valid && clear_op && instr_dest_status
    ##0 quiet |=> status_flags == ($past(status_flags) | 8'h04))
    else $error("clear of status wrong");
  no_flag_ops_a: assert property (instr_valid && !instr_dest_status && plain_op
    |=> $stable(status_flags[2:0]))
    else $error("flag changed by plain op");
  dest_drop_a: assert property (instr_valid && instr_dest_status && logic_op
    |=> $stable(status_flags[1:0]))
    else $error("status write not dropped");
  sleep_flag_a: assert property (sleep_instr && !watchdog_clear_instr
    && !watchdog_timeout |=> status_flags[4:3] == 2'b10)
    else $error("sleep flags wrong");
  wdclr_flag_a: assert property (watchdog_clear_instr && !sleep_instr
    && !watchdog_timeout |=> status_flags[4:3] == 2'b11)
    else $error("watchdog clear flags wrong");
  timeout_flag_a: assert property (watchdog_timeout |=> !status_flags[4])
    else $error("expiry flag not cleared");
  ctrl_hold_a: assert property (quiet |=> $stable(status_flags[4:3]))
    else $error("reset cause flags changed");
endmodule

bind asf_status asf_status_monitor i_mon (.*);

/* tb/tb.sv */
// Self-checking bench for asf_status.
// Drives bus, instruction and event ports itself; no partner model.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = '0, araddr = '0, wstrb = '0;
  logic [31:0] wdata = '0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, result_valid;
  logic [1:0] bresp, rresp;
  logic instr_valid = 0, instr_dest_status = 0;
  asf_pkg::asf_op_type instr_op = asf_pkg::OP_ADD;
  logic [7:0] instr_operand_f = '0, instr_operand_w = '0, result, status_flags;
  logic [2:0] instr_bit_sel = '0;
  logic sleep_instr = 0, watchdog_clear_instr = 0, watchdog_timeout = 0;
  logic [7:0] sf, lr;
  logic [31:0] expq[$];
  int n_mismatch = 0;
  int num_checks = 0;

  asf_status i_asf_status (.*);

  always #20 aclk = ~aclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Oldest note matches each result pulse
  always @(posedge aclk)
    if (result_valid === 1'b1)
      chk(32'({result, status_flags}), expq.size() > 0 ? expq.pop_front() : 'x);

  task automatic ins(input asf_pkg::asf_op_type op, input logic [7:0] f, w,
    input logic [2:0] b, input logic d);
    logic sb;
    logic [7:0] o, r;
    logic [8:0] s;
    logic [4:0] nb;
    sb = op == asf_pkg::OP_SUB;
    o = sb ? ~w : w;
    s = {1'b0, f} + {1'b0, o} + {8'h00, sb};
    nb = {1'b0, f[3:0]} + {1'b0, o[3:0]} + {4'h0, sb};
    case (op)
      asf_pkg::OP_ADD, asf_pkg::OP_SUB: r = s[7:0];
      asf_pkg::OP_AND: r = f & w;
      asf_pkg::OP_OR: r = f | w;
      asf_pkg::OP_XOR: r = f ^ w;
      asf_pkg::OP_BIT_CLEAR: r = f & ~(8'h01 << b);
      asf_pkg::OP_BIT_SET: r = f | (8'h01 << b);
      asf_pkg::OP_SWAP: r = {f[3:0], f[7:4]};
      asf_pkg::OP_MOVE: r = w;
      default: r = 8'h00;
    endcase
    if (op inside {asf_pkg::OP_ADD, asf_pkg::OP_SUB})
      sf[2:0] = {r == 8'h00, nb[4], s[8]};
    else if (op inside {asf_pkg::OP_AND, asf_pkg::OP_OR, asf_pkg::OP_XOR, asf_pkg::OP_CLEAR})
      sf[2] = r == 8'h00;
    else if (d)
      sf[2:0] = r[2:0];
    lr = r;
    expq.push_back({16'h0000, r, sf});
    instr_valid <= 1'b1;
    instr_op <= op;
    instr_operand_f <= f;
    instr_operand_w <= w;
    instr_bit_sel <= b;
    instr_dest_status <= d;
    @(posedge aclk);
  endtask

  task automatic ev(input logic s, c, t);
    instr_valid <= 1'b0;
    sleep_instr <= s;
    watchdog_clear_instr <= c;
    watchdog_timeout <= t;
    @(posedge aclk);
    sleep_instr <= 1'b0;
    watchdog_clear_instr <= 1'b0;
    watchdog_timeout <= 1'b0;
    sf[4] = t ? 1'b0 : (s | c) ? 1'b1 : sf[4];
    sf[3] = c ? 1'b1 : s ? 1'b0 : sf[3];
    @(posedge aclk);
    chk(32'(status_flags), 32'(sf));
  endtask

  // Each valid drops only at its own handshake; ready to answers stays up,
  // so a following call never drives a signal twice in one step
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    chk(32'(bresp), 32'(er));
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    chk(rdata, ed);
    chk(32'(rresp), 32'(er));
  endtask

  initial
  begin
    repeat (6000) @(posedge aclk);
    n_mismatch++;
    end_of_test();
  end

  initial
  begin
    logic [31:0] v;
    void'($urandom(32'hf662_0050));
    sf = 8'h18;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(32'(status_flags), 32'h0000_0018);
    rd(4'h0, 32'h0000_0018, asf_pkg::RESP_OKAY);
    $display("Test reset done");
    // Edge cases first: wrap, borrow, equal, clear of status
    ins(asf_pkg::OP_ADD, 8'hff, 8'h01, 3'h0, 1'b1);
    ins(asf_pkg::OP_SUB, 8'h00, 8'h01, 3'h0, 1'b0);
    ins(asf_pkg::OP_SUB, 8'h05, 8'h05, 3'h0, 1'b1);
    ins(asf_pkg::OP_CLEAR, 8'h5a, 8'h00, 3'h0, 1'b1);
    repeat (300)
    begin
      v = $urandom;
      ins(asf_pkg::asf_op_type'(4'($urandom_range(9))), v[7:0], v[15:8], v[18:16], v[19]);
    end
    instr_valid <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(32'(expq.size()), 32'h0000_0000);
    $display("Test instructions done");
    ev(1'b1, 1'b0, 1'b0);
    ev(1'b0, 1'b1, 1'b0);
    ev(1'b0, 1'b0, 1'b1);
    ev(1'b0, 1'b1, 1'b1);
    ev(1'b1, 1'b0, 1'b0);
    $display("Test events done");
    wr(4'h0, 32'hffff_ffff, asf_pkg::RESP_OKAY);
    sf[2:0] = 3'h7;
    rd(4'h0, 32'(sf), asf_pkg::RESP_OKAY);
    wr(4'h0, 32'h0000_0000, asf_pkg::RESP_OKAY);
    sf[2:0] = 3'h0;
    rd(4'h0, 32'(sf), asf_pkg::RESP_OKAY);
    rd(4'h4, 32'(lr), asf_pkg::RESP_OKAY);
    wr(4'h8, 32'h0000_0007, asf_pkg::RESP_SLVERR);
    rd(4'hc, 32'h0000_0000, asf_pkg::RESP_SLVERR);
    rd(4'h0, 32'(sf), asf_pkg::RESP_OKAY);
    $display("Test bus done");
    // Second power-on: sleep-entered was zero, must come back to one
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    sf = 8'h18;
    @(posedge aclk);
    chk(32'(status_flags), 32'h0000_0018);
    rd(4'h0, 32'(sf), asf_pkg::RESP_OKAY);
    $display("Test reset again done");
    end_of_test();
  end
endmodule
